/* File: verilog/ufm_rx_defines.svh */
// constants for the push-pull two-wire receive-only slave
// assumes inclusion by bare name from design files
`ifndef UFM_RX_DEFINES_SVH
`define UFM_RX_DEFINES_SVH
`define GC_ADDR 7'h00
`define START_BYTE 8'h01
`define GC_RESET_LOAD 8'h06
`define GC_LOAD 8'h04
`define TEN_PREFIX 5'h1e
`define BITS_PER_BYTE 4'h8
`define NINTH_BIT 4'h8
`endif

/* File: verilog/ufm_rx_pkg.sv */
// types shared by the receive-only slave and its byte fifo
// assumes the defines header is available
`default_nettype none
package ufm_rx_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ADDR2 = 3'b010,
		ST_DATA = 3'b011,
		ST_GC = 3'b100,
		ST_SKIP = 3'b101
	} phase_e;
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} rx_word_s;
endpackage
`default_nettype wire

/* File: verilog/byte_fifo.sv */
// synchronous fifo with registered read data
// assumes one clock and asynchronous active-low reset
`default_nettype none
module byte_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic mclk, // system clock
	input wire logic arst_n, // async reset, active low
	input wire logic in_valid, // write request
	output logic in_ready, // not full
	input wire logic [WIDTH-1:0] in_data, // write data
	output logic out_valid, // read data valid
	input wire logic out_ready, // consumer takes data
	output logic [WIDTH-1:0] out_data // registered read data
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [AW:0] wp;
		logic [AW:0] rp;
		logic ov;
		logic [WIDTH-1:0] od;
	} fifo_state_s;
	fifo_state_s s_q;
	fifo_state_s s_d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic full;
	logic empty;
	logic wr;
	logic rd;
	assign full = (s_q.wp[AW] != s_q.rp[AW]) && (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
	assign empty = s_q.wp == s_q.rp;
	assign wr = in_valid && !full;
	assign rd = !empty && (!s_q.ov || out_ready);
	assign in_ready = !full;
	assign out_valid = s_q.ov;
	assign out_data = s_q.od;
	always_comb
	begin
		s_d = s_q;
		if (wr)
		begin
			s_d.wp = s_q.wp + 1'b1;
		end
		if (out_ready && s_q.ov)
		begin
			s_d.ov = 1'b0;
		end
		if (rd)
		begin
			s_d.od = mem[s_q.rp[AW-1:0]];
			s_d.ov = 1'b1;
			s_d.rp = s_q.rp + 1'b1;
		end
	end
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end
	always_ff @(posedge mclk)
	begin
		if (wr)
		begin
			mem[s_q.wp[AW-1:0]] <= in_data;
		end
	end
	a_fifo_no_overfill: assert property (@(posedge mclk) disable iff (!arst_n)
		full |-> ##1 (s_q.wp == $past(s_q.wp)))
		else $error("fifo write pointer moved while full");
endmodule
`default_nettype wire

/* File: verilog/ufm_rx_slave.sv */
// receive-only slave for the push-pull ultra fast two-wire bus
// assumes bus pins asynchronous to mclk and a bus clock well below mclk/4
// Notes on behaviour
// - slave never drives the data line and never acknowledges.
// - every start resets protocol state and expects an address.
// - start followed directly by stop returns quietly to idle.
// - ninth bit after each byte is skipped without response.
// - ten-bit first byte is 11110, two address msbs, direction bit.
// - ten-bit match needs prefix and write, then full second byte.
// - matched slave stays addressed until stop or new start.
// - prefixes 11111xx are reserved, never decoded as ten-bit.
// - 0000xxx and 1111xxx addresses never match an ordinary slave.
// - general call bytes are received, unknown ones ignored.
// - general call 06h resets logic and latches address pins.
// - general call 04h latches address pins without reset.
// - all other general call codes, 00h included, are ignored.
// - general call second byte with low bit one is ignored.
// - software reset can be disabled and then has no effect.
// - start byte is discarded by resetting on the repeated start.
// - start byte may precede ten-bit addressing as well.
// - no device identification readout is provided.
// - start is data falling with clock high, stop data rising.
// - bytes shift in msb first, sampled on clock rising edge.
`include "ufm_rx_defines.svh"
`default_nettype none
module ufm_rx_slave #(
	parameter bit TEN_BIT = 1'b0,
	parameter bit GC_ENABLE = 1'b1,
	parameter bit SWRST_ENABLE = 1'b1,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic mclk, // system clock, 20 MHz
	input wire logic arst_n, // async reset, active low
	input wire logic uscl, // bus clock pin
	input wire logic usda, // bus data pin, input only
	input wire logic [9:0] addr_pins, // hardware address source
	output logic [7:0] rx_data, // received byte
	output logic rx_last, // last flag, always zero (stop is shown on xfer_end)
	output logic rx_valid, // byte valid
	input wire logic rx_ready, // consumer takes byte
	output logic xfer_end, // pulse on stop after addressed transfer
	output logic soft_reset, // pulse on general call reset
	output logic [9:0] own_addr, // latched own address
	output logic busy // bus between start and stop
);
	// ************************************************************
	// state record
	// ************************************************************
	typedef struct packed {
		logic [1:0] scl_sync;
		logic [1:0] sda_sync;
		logic scl_prev;
		logic sda_prev;
		ufm_rx_pkg::phase_e phase;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic addressed;
		logic pend_valid;
		ufm_rx_pkg::rx_word_s pend;
		logic end_q;
		logic srst_q;
		logic [9:0] addr_q;
		logic busy_q;
		logic load_q;
	} slave_state_s;
	slave_state_s s_q;
	slave_state_s s_d;
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic start_ev;
	logic stop_ev;
	logic byte_done;
	logic [7:0] nbyte;
	logic fifo_ready;
	assign scl_s = s_q.scl_sync[1];
	assign sda_s = s_q.sda_sync[1];
	assign scl_rise = scl_s && !s_q.scl_prev;
	assign start_ev = scl_s && s_q.scl_prev && s_q.sda_prev && !sda_s;
	assign stop_ev = scl_s && s_q.scl_prev && !s_q.sda_prev && sda_s;
	assign nbyte = {s_q.shreg[6:0], sda_s};
	assign byte_done = scl_rise && (s_q.bitcnt == `BITS_PER_BYTE - 4'h1);
	// ************************************************************
	// protocol engine
	// ************************************************************
	always_comb
	begin
		s_d = s_q;
		s_d.scl_sync = {s_q.scl_sync[0], uscl};
		s_d.sda_sync = {s_q.sda_sync[0], usda};
		s_d.scl_prev = scl_s;
		s_d.sda_prev = sda_s;
		s_d.end_q = 1'b0;
		s_d.srst_q = 1'b0;
		s_d.load_q = 1'b0;
		if (s_q.load_q)
		begin
			s_d.addr_q = addr_pins;
		end
		if (s_q.pend_valid && fifo_ready)
		begin
			s_d.pend_valid = 1'b0;
		end
		if (start_ev)
		begin
			s_d.phase = ufm_rx_pkg::ST_ADDR;
			s_d.bitcnt = 4'h0;
			s_d.busy_q = 1'b1;
			s_d.addressed = 1'b0;
		end
		else if (stop_ev)
		begin
			s_d.phase = ufm_rx_pkg::ST_IDLE;
			s_d.busy_q = 1'b0;
			s_d.end_q = s_q.addressed;
			s_d.addressed = 1'b0;
		end
		else if (scl_rise && s_q.phase != ufm_rx_pkg::ST_IDLE)
		begin
			if (s_q.bitcnt == `NINTH_BIT)
			begin
				s_d.bitcnt = 4'h0;
			end
			else
			begin
				s_d.shreg = nbyte;
				s_d.bitcnt = s_q.bitcnt + 4'h1;
			end
			if (byte_done)
			begin
				unique case (s_q.phase)
					ufm_rx_pkg::ST_ADDR:
					begin
						if (TEN_BIT && nbyte[7:3] == `TEN_PREFIX && !nbyte[0]
							&& nbyte[2:1] == s_q.addr_q[9:8])
						begin
							s_d.phase = ufm_rx_pkg::ST_ADDR2;
						end
						else if (GC_ENABLE && nbyte == {`GC_ADDR, 1'b0})
						begin
							s_d.phase = ufm_rx_pkg::ST_GC;
						end
						else if (!TEN_BIT && !nbyte[0] && nbyte[7:4] != 4'h0
							&& nbyte[7:4] != 4'hf && nbyte[7:1] == s_q.addr_q[6:0])
						begin
							s_d.phase = ufm_rx_pkg::ST_DATA;
							s_d.addressed = 1'b1;
						end
						else
						begin
							s_d.phase = ufm_rx_pkg::ST_SKIP;
						end
					end
					ufm_rx_pkg::ST_ADDR2:
					begin
						if (nbyte == s_q.addr_q[7:0])
						begin
							s_d.phase = ufm_rx_pkg::ST_DATA;
							s_d.addressed = 1'b1;
						end
						else
						begin
							s_d.phase = ufm_rx_pkg::ST_SKIP;
						end
					end
					ufm_rx_pkg::ST_GC:
					begin
						s_d.phase = ufm_rx_pkg::ST_SKIP;
						if (nbyte == `GC_RESET_LOAD && SWRST_ENABLE)
						begin
							s_d.srst_q = 1'b1;
							s_d.load_q = 1'b1;
							s_d.pend_valid = 1'b0;
						end
						else if (nbyte == `GC_LOAD)
						begin
							s_d.load_q = 1'b1;
						end
					end
					ufm_rx_pkg::ST_DATA:
					begin
						s_d.pend_valid = 1'b1;
						s_d.pend.data = nbyte;
						s_d.pend.last = 1'b0;
					end
					ufm_rx_pkg::ST_SKIP:
					begin
						s_d.phase = ufm_rx_pkg::ST_SKIP;
					end
					default:
					begin
						s_d.phase = ufm_rx_pkg::ST_IDLE;
					end
				endcase
			end
		end
	end
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			s_q <= '0;
			s_q.scl_sync <= 2'h3;
			s_q.sda_sync <= 2'h3;
			s_q.scl_prev <= 1'b1;
			s_q.sda_prev <= 1'b1;
			s_q.load_q <= 1'b1;
		end
		else
		begin
			s_q <= s_d;
		end
	end
	// ************************************************************
	// byte buffer and outputs
	// ************************************************************
	ufm_rx_pkg::rx_word_s fifo_out;
	byte_fifo #(
		.WIDTH($bits(ufm_rx_pkg::rx_word_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk(mclk),
		.arst_n(arst_n),
		.in_valid(s_q.pend_valid),
		.in_ready(fifo_ready),
		.in_data(s_q.pend),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(fifo_out)
	);
	assign rx_data = fifo_out.data;
	assign rx_last = fifo_out.last;
	assign xfer_end = s_q.end_q;
	assign soft_reset = s_q.srst_q;
	assign own_addr = s_q.addr_q;
	assign busy = s_q.busy_q;
	// ************************************************************
	// checks
	// ************************************************************
	a_start_resync: assert property (@(posedge mclk) disable iff (!arst_n)
		start_ev |=> (s_q.phase == ufm_rx_pkg::ST_ADDR && s_q.bitcnt == 4'h0))
		else $error("start did not resync protocol");
	a_stop_idle: assert property (@(posedge mclk) disable iff (!arst_n)
		stop_ev |=> (s_q.phase == ufm_rx_pkg::ST_IDLE && !s_q.busy_q))
		else $error("stop did not return to idle");
	a_reserved_no_match: assert property (@(posedge mclk) disable iff (!arst_n)
		(byte_done && s_q.phase == ufm_rx_pkg::ST_ADDR && !start_ev && !stop_ev
		&& (nbyte[7:4] == 4'h0 || nbyte[7:3] == 5'h1f)) |=> !s_q.addressed)
		else $error("reserved address matched");
	a_read_no_match: assert property (@(posedge mclk) disable iff (!arst_n)
		(byte_done && s_q.phase == ufm_rx_pkg::ST_ADDR && nbyte[0]) |=> !s_q.addressed)
		else $error("read direction addressed slave");
	a_gc_load_addr: assert property (@(posedge mclk) disable iff (!arst_n)
		(byte_done && s_q.phase == ufm_rx_pkg::ST_GC && !start_ev && !stop_ev
		&& nbyte == 8'h04) |=> ##1 (s_q.addr_q == $past(addr_pins)))
		else $error("address not latched on load command");
	a_gc_odd_ignored: assert property (@(posedge mclk) disable iff (!arst_n)
		(byte_done && s_q.phase == ufm_rx_pkg::ST_GC && nbyte[0]) |=> (!s_q.srst_q
		&& !s_q.load_q))
		else $error("odd general call byte acted on");
	a_data_strobe: assert property (@(posedge mclk) disable iff (!arst_n)
		(byte_done && s_q.phase == ufm_rx_pkg::ST_DATA && !start_ev && !stop_ev)
		|=> (s_q.pend_valid && s_q.pend.data == $past(nbyte)))
		else $error("data byte not forwarded");
	a_end_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
		s_q.end_q |=> !s_q.end_q)
		else $error("end of transfer not a single pulse");
	a_ninth_skip: assert property (@(posedge mclk) disable iff (!arst_n)
		(scl_rise && s_q.bitcnt == 4'h8 && !start_ev && !stop_ev
		&& s_q.phase != ufm_rx_pkg::ST_IDLE) |=> (s_q.bitcnt == 4'h0))
		else $error("ninth bit not skipped");
	a_start_busy: assert property (@(posedge mclk) disable iff (!arst_n)
		start_ev |=> s_q.busy_q)
		else $error("start did not mark bus busy");
	a_gc_reset_cmd: assert property (@(posedge mclk) disable iff (!arst_n)
		(byte_done && s_q.phase == ufm_rx_pkg::ST_GC && nbyte == 8'h06)
		|=> (s_q.srst_q == SWRST_ENABLE && s_q.load_q))
		else $error("reset command not handled");
	a_ten_reserved: assert property (@(posedge mclk) disable iff (!arst_n)
		(byte_done && s_q.phase == ufm_rx_pkg::ST_ADDR && nbyte[7:3] == 5'h1f)
		|=> (s_q.phase != ufm_rx_pkg::ST_ADDR2))
		else $error("reserved prefix decoded as ten-bit");
	a_ten_second: assert property (@(posedge mclk) disable iff (!arst_n)
		(byte_done && s_q.phase == ufm_rx_pkg::ST_ADDR2 && nbyte != s_q.addr_q[7:0])
		|=> !s_q.addressed)
		else $error("ten-bit second byte mismatch addressed slave");
endmodule
`default_nettype wire

/* File: sim/ufm_bus_master.sv */
// bus master model for the push-pull two-wire bus, clock and data
// assumes delays in ns; bit period 400 ns; clock stands high between frames
`default_nettype none
module ufm_bus_master (
	output logic uscl, // bus clock
	output logic usda // bus data
);
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// bus conditions and bits
	// ************************************************************
	initial
	begin
		uscl = 1'b1;
		usda = 1'b1;
	end

	task automatic put_bits(input logic [7:0] b, input int n);
		for (int i = 7; i > 7 - n; i--)
		begin
			usda = b[i];
			#100 uscl = 1'b1;
			#200 uscl = 1'b0;
			#100;
		end
	endtask

	task automatic put_byte(input logic [7:0] b);
		put_bits(b, 8);
		put_bits(8'hff, 1);
	endtask

	task automatic start;
		usda = 1'b1;
		#100 uscl = 1'b1;
		#100 usda = 1'b0;
		#100 uscl = 1'b0;
	endtask

	task automatic stop;
		usda = 1'b0;
		#100 uscl = 1'b1;
		#100 usda = 1'b1;
		#200;
	endtask
endmodule
`default_nettype wire

/* File: sim/test_ufm_serial_slave_receiver.sv */
// self-checking bench for the receive-only two-wire slave
// assumes the design files and the bus master model are compiled first
`default_nettype none
module test_ufm_serial_slave_receiver;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic rx_ready = 1'b0;
	logic [9:0] addr_pins = 10'h02a;
	logic uscl, usda, rx_last, rx_valid, xfer_end, soft_reset, busy;
	logic [9:0] own_addr;
	logic [7:0] rx_data;
	logic [7:0] rx_data10;
	logic rx_valid10, rx_last10, xfer_end10, soft_reset10, busy10;
	logic [9:0] own_addr10;
	int ends10 = 0;
	int got10 = 0;
	logic [7:0] exp_q[$];
	logic [31:0] seed = 32'h0000f0bb;
	int mismatches = 0;
	int checked = 0;
	int ends = 0;
	int resets = 0;

	initial
	begin
		forever #25 mclk = ~mclk;
	end

	ufm_rx_slave i_dut (.mclk(mclk), .arst_n(arst_n), .uscl(uscl), .usda(usda),
		.addr_pins(addr_pins), .rx_data(rx_data), .rx_last(rx_last), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .xfer_end(xfer_end), .soft_reset(soft_reset),
		.own_addr(own_addr), .busy(busy));
	ufm_rx_slave #(.TEN_BIT(1'b1)) i_dut_ten (.mclk(mclk), .arst_n(arst_n), .uscl(uscl),
		.usda(usda), .addr_pins(addr_pins), .rx_data(rx_data10), .rx_last(rx_last10),
		.rx_valid(rx_valid10), .rx_ready(rx_ready), .xfer_end(xfer_end10),
		.soft_reset(soft_reset10), .own_addr(own_addr10), .busy(busy10));
	ufm_bus_master i_master (.uscl(uscl), .usda(usda));

	// ************************************************************
	// helpers
	// ************************************************************
	function logic [31:0] xorshift;
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task cmp_val(input string what, input logic [9:0] e, input logic [9:0] g);
		checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask

	task cmp_byte(input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("wrong value rx_data expected %h seen %h", e, g);
		end
	endtask

	task final_report;
		if (mismatches == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task send(input logic [7:0] b, input bit keep);
		if (keep)
			exp_q.push_back(b);
		i_master.put_byte(b);
	endtask

	task frame(input logic [7:0] a, input int n, input bit keep);
		logic [31:0] r;
		i_master.start();
		send(a, 1'b0);
		repeat (n)
		begin
			r = xorshift();
			send(r[7:0], keep);
		end
	endtask

	task settle;
		int k;
		k = 0;
		while (exp_q.size() != 0 && k < 400)
		begin
			@(posedge mclk);
			k++;
		end
		if (k == 400)
		begin
			mismatches++;
			$display("wrong value byte queue expected 0 seen %0d", exp_q.size());
			final_report;
		end
		repeat (10) @(posedge mclk);
	endtask

	task gc(input logic [7:0] code);
		frame(8'h00, 0, 1'b0);
		send(code, 1'b0);
		i_master.stop();
		settle;
	endtask

	task ten(input logic [7:0] first, input logic [7:0] second);
		frame(first, 0, 1'b0);
		send(second, 1'b0);
		send(8'h3c, 1'b0);
		i_master.stop();
		settle;
	endtask

	always @(negedge mclk)
		rx_ready <= ^xorshift();

	always @(posedge mclk)
	begin
		if (xfer_end === 1'b1)
			ends++;
		if (soft_reset === 1'b1)
			resets++;
		if (xfer_end10 === 1'b1)
			ends10++;
		if (rx_valid10 === 1'b1 && rx_ready === 1'b1)
		begin
			got10++;
			cmp_byte(8'h3c, rx_data10);
		end
		if (rx_valid === 1'b1 && rx_ready === 1'b1)
		begin
			if (exp_q.size() == 0)
			begin
				mismatches++;
				$display("wrong value rx_valid expected 0 seen 1");
			end
			else
				cmp_byte(exp_q.pop_front(), rx_data);
			cmp_val("rx_last", 10'h000, {9'h000, rx_last});
		end
	end

	// ************************************************************
	// scenarios
	// ************************************************************
	initial
	begin
		logic [7:0] bad[6] = '{8'h56, 8'h55, 8'h04, 8'h08, 8'hf4, 8'hfe};
		logic [7:0] odd[3] = '{8'h07, 8'h00, 8'h08};
		repeat (6) @(negedge mclk);
		arst_n = 1'b1;
		repeat (8) @(negedge mclk);
		cmp_val("own_addr", 10'h02a, own_addr);
		frame(8'h54, 3, 1'b1);
		cmp_val("busy", 10'h001, {9'h000, busy});
		i_master.stop();
		settle;
		cmp_val("busy", 10'h000, {9'h000, busy});
		cmp_val("xfer_end count", 10'h001, 10'(ends));
		foreach (bad[i])
		begin
			frame(bad[i], 2, 1'b0);
			i_master.stop();
			settle;
		end
		cmp_val("xfer_end count", 10'h001, 10'(ends));
		i_master.start();
		send(8'h01, 1'b0);
		frame(8'h54, 1, 1'b1);
		i_master.stop();
		settle;
		cmp_val("xfer_end count", 10'h002, 10'(ends));
		ten(8'hf0, 8'h2a);
		i_master.start();
		send(8'h01, 1'b0);
		ten(8'hf0, 8'h2a);
		ten(8'hf8, 8'h2a);
		ten(8'hf0, 8'h2b);
		ten(8'hf1, 8'h2a);
		cmp_val("ten-bit end count", 10'h002, 10'(ends10));
		cmp_val("ten-bit byte count", 10'h002, 10'(got10));
		cmp_val("xfer_end count", 10'h002, 10'(ends));
		i_master.start();
		send(8'h54, 1'b0);
		i_master.put_bits(8'hff, 3);
		frame(8'h54, 2, 1'b1);
		frame(8'h56, 2, 1'b0);
		i_master.stop();
		settle;
		i_master.start();
		i_master.stop();
		settle;
		cmp_val("busy", 10'h000, {9'h000, busy});
		frame(8'h54, 1, 1'b1);
		i_master.stop();
		settle;
		@(negedge mclk);
		addr_pins = 10'h033;
		foreach (odd[i])
		begin
			gc(odd[i]);
			cmp_val("own_addr", 10'h02a, own_addr);
		end
		gc(8'h04);
		cmp_val("own_addr", 10'h033, own_addr);
		cmp_val("soft_reset count", 10'h000, 10'(resets));
		frame(8'h66, 2, 1'b1);
		i_master.stop();
		settle;
		@(negedge mclk);
		addr_pins = 10'h02a;
		gc(8'h06);
		cmp_val("own_addr", 10'h02a, own_addr);
		cmp_val("soft_reset count", 10'h001, 10'(resets));
		@(negedge mclk);
		addr_pins = 10'h004;
		gc(8'h04);
		frame(8'h08, 2, 1'b0);
		i_master.stop();
		settle;
		final_report;
	end
endmodule
`default_nettype wire
